// [core/acbc_pkg.sv]
// Package of constants and types for the capture buffer control block
package acbc_pkg;

  // ============================================================
  // Register map
  localparam logic [31:0] ACBC_CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] ACBC_STATUS_ADDR = 32'h0000_0004;
  localparam logic [7:0]  ACBC_CTRL_RESET  = 8'h20;

  // Control field positions
  localparam int ACBC_F_DEPTH = 0;
  localparam int ACBC_F_PLL   = 2;
  localparam int ACBC_F_ASTOP = 4;
  localparam int ACBC_F_EDGE  = 5;
  localparam int ACBC_F_FSD   = 6;
  localparam int ACBC_F_CSD   = 7;

  // Status field positions
  localparam int ACBC_S_EMPTY  = 0;
  localparam int ACBC_S_FULL   = 1;
  localparam int ACBC_S_FILLED = 2;
  localparam int ACBC_S_COUNT  = 16;

  // ============================================================
  // Buffer geometry
  localparam int          ACBC_AW       = 10;
  localparam int          ACBC_CW       = 11;
  localparam int          ACBC_MEM_WORDS = 1024;
  localparam logic [1:0]  ACBC_DEPTH_BYPASS = 2'h0;
  localparam logic [1:0]  ACBC_DEPTH_256    = 2'h1;
  localparam logic [1:0]  ACBC_DEPTH_512    = 2'h2;
  localparam logic [10:0] ACBC_N_256  = 11'h100;
  localparam logic [10:0] ACBC_N_512  = 11'h200;
  localparam logic [10:0] ACBC_N_1024 = 11'h400;

  // PLL multipliers
  localparam logic [1:0] ACBC_PLL_BYPASS = 2'h0;
  localparam logic [1:0] ACBC_PLL_X2     = 2'h1;
  localparam logic [1:0] ACBC_PLL_X4     = 2'h2;
  localparam logic [3:0] ACBC_MULT_1 = 4'h1;
  localparam logic [3:0] ACBC_MULT_2 = 4'h2;
  localparam logic [3:0] ACBC_MULT_4 = 4'h4;
  localparam logic [3:0] ACBC_MULT_8 = 4'h8;

  // ============================================================
  // Types
  typedef struct packed {
    logic       converter_shutdown;
    logic       full_shutdown;
    logic       strobe_edge_select;
    logic       auto_stop_on_full;
    logic [1:0] pll_ratio_select;
    logic [1:0] depth_select;
  } acbc_ctrl_t;

  typedef struct packed {
    logic       enable;
    logic [3:0] mult;
  } acbc_pll_t;

  typedef enum logic [1:0] {
    ACBC_IDLE  = 2'b00,
    ACBC_WRITE = 2'b01,
    ACBC_READY = 2'b10
  } acbc_state_t;

endpackage

// [core/acbc_top.sv]
// Capture buffer control: AHB-Lite registers, sample FIFO, read port, strobe
// ============================================================
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module acbc_top (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  input  wire logic [7:0]           i_adc_sample,
  input  wire logic                 i_buffer_reset,
  input  wire logic                 i_capture_write_enable,
  input  wire logic                 i_buffer_read_enable,
  input  wire logic                 i_buffer_read_clock,
  output logic      [7:0]           o_sample_data,
  output logic                      o_output_strobe,
  output logic                      o_empty_flag_out,
  output logic                      o_full_flag_out,
  output logic                      o_converter_power_down,
  output acbc_pkg::acbc_pll_t       o_pll
);
  import acbc_pkg::*;

  // ============================================================
  // Decode helpers
  function automatic logic [10:0] depth_bytes(input logic [1:0] sel);
    case (sel)
      ACBC_DEPTH_256: depth_bytes = ACBC_N_256;
      ACBC_DEPTH_512: depth_bytes = ACBC_N_512;
      default:        depth_bytes = ACBC_N_1024;
    endcase
  endfunction

  function automatic logic [3:0] pll_mult(input logic [1:0] sel);
    case (sel)
      ACBC_PLL_BYPASS: pll_mult = ACBC_MULT_1;
      ACBC_PLL_X2:     pll_mult = ACBC_MULT_2;
      ACBC_PLL_X4:     pll_mult = ACBC_MULT_4;
      default:         pll_mult = ACBC_MULT_8;
    endcase
  endfunction

  // ============================================================
  // Pin synchronisers; only stage two is read by logic
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       rclk_prev_q;
  logic       wen_prev_q;
  logic       buf_rst;
  logic       wen_s;
  logic       ren_s;
  logic       rclk_s;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_buffer_read_clock, i_buffer_read_enable,
                  i_capture_write_enable, i_buffer_reset};
      sync2_q <= sync1_q;
    end
  end

  assign buf_rst = sync2_q[0];
  assign wen_s   = sync2_q[1];
  assign ren_s   = sync2_q[2];
  assign rclk_s  = sync2_q[3];

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rclk_prev_q <= 1'b0;
      wen_prev_q  <= 1'b0;
    end else begin
      rclk_prev_q <= rclk_s;
      wen_prev_q  <= wen_s;
    end
  end

  // ============================================================
  // AHB-Lite slave, zero wait states
  acbc_ctrl_t  ctrl_q;
  logic        dp_write_q;
  logic        dp_ctrl_q;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [10:0] count_q;
  logic        filled_q;

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_haddr == ACBC_CTRL_ADDR) begin
      rd_mux[7:0] = ctrl_q;
    end else if (i_haddr == ACBC_STATUS_ADDR) begin
      rd_mux[ACBC_S_EMPTY]  = o_empty_flag_out;
      rd_mux[ACBC_S_FULL]   = o_full_flag_out;
      rd_mux[ACBC_S_FILLED] = filled_q;
      rd_mux[ACBC_S_COUNT +: ACBC_CW] = count_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dp_write_q  <= 1'b0;
      dp_ctrl_q   <= 1'b0;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      dp_write_q  <= addr_ok && i_hwrite;
      dp_ctrl_q   <= i_haddr == ACBC_CTRL_ADDR;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_q <= ACBC_CTRL_RESET;
    end else if (dp_write_q && dp_ctrl_q) begin
      ctrl_q <= i_hwdata[7:0];
    end
  end

  // ============================================================
  // Mode decode
  logic bypass;
  logic sd_full;
  logic sd_conv;
  logic [10:0] depth;

  assign bypass  = ctrl_q.depth_select == ACBC_DEPTH_BYPASS;
  assign depth   = depth_bytes(ctrl_q.depth_select);
  assign sd_full = ctrl_q.full_shutdown;
  assign sd_conv = ctrl_q.converter_shutdown;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pll                  <= '0;
      o_converter_power_down <= 1'b1;
    end else begin
      o_pll.mult             <= pll_mult(ctrl_q.pll_ratio_select);
      o_pll.enable           <= !sd_full &&
                                ctrl_q.pll_ratio_select != ACBC_PLL_BYPASS;
      o_converter_power_down <= sd_full || sd_conv;
    end
  end

  // ============================================================
  // Buffer write and read control
  logic [7:0]     mem [ACBC_MEM_WORDS];
  logic [9:0]     wr_ptr_q;
  logic [9:0]     rd_ptr_q;
  acbc_state_t    state_q;
  logic           wen_rise;
  logic           full_now;
  logic           wr_go;
  logic           rd_go;
  logic           rclk_rise;
  logic           rclk_fall;
  logic [9:0]     wr_base;
  logic [9:0]     wr_next;
  logic [10:0]    cnt_base;
  logic [10:0]    count_d;

  assign rclk_rise = rclk_s && !rclk_prev_q;
  assign rclk_fall = !rclk_s && rclk_prev_q;
  // A rise that the mode ignores must not clear the stored capture
  assign wen_rise  = wen_s && !wen_prev_q && !bypass && !sd_full && !sd_conv;
  assign wr_base   = wen_rise ? 10'h000 : wr_ptr_q;
  assign cnt_base  = wen_rise ? 11'h000 : count_q;
  assign full_now  = cnt_base == depth;
  // Converter shutdown and auto-stop both block storage
  assign wr_go = wen_s && !bypass && !sd_full && !sd_conv
                 && !(ctrl_q.auto_stop_on_full && full_now);
  // Write enable blocks every read, regardless of which rose first
  assign rd_go = ren_s && !wen_s && rclk_rise && filled_q
                 && count_q != 11'h000 && !bypass && !sd_full;
  assign wr_next = (11'(wr_base) + 11'h001 == depth) ? 10'h000 : wr_base + 10'h001;

  always_comb begin
    count_d = cnt_base;
    if (wr_go && !full_now) begin
      count_d = cnt_base + 11'h001;
    end else if (rd_go) begin
      count_d = count_q - 11'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (wr_go) begin
      mem[wr_base] <= i_adc_sample;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst || buf_rst) begin
      wr_ptr_q <= 10'h000;
      rd_ptr_q <= 10'h000;
      count_q  <= 11'h000;
      filled_q <= 1'b0;
      state_q  <= ACBC_IDLE;
    end else begin
      count_q <= count_d;
      if (wen_rise) begin
        rd_ptr_q <= 10'h000;
        filled_q <= 1'b0;
      end
      if (wr_go) begin
        wr_ptr_q <= wr_next;
        if (full_now) begin
          rd_ptr_q <= wr_next;
        end
        if (count_d == depth) begin
          filled_q <= 1'b1;
        end
      end else if (rd_go) begin
        rd_ptr_q <= (11'(rd_ptr_q) + 11'h001 == depth) ? 10'h000 : rd_ptr_q + 10'h001;
      end
      case (state_q)
        ACBC_IDLE:  if (wr_go) state_q <= ACBC_WRITE;
        ACBC_WRITE: if (!wen_s && filled_q) state_q <= ACBC_READY;
        ACBC_READY: if (wr_go) state_q <= ACBC_WRITE;
        default:    state_q <= ACBC_IDLE;
      endcase
    end
  end

  // ============================================================
  // Flags, registered on the sample clock
  always_ff @(posedge i_core_clk) begin
    if (i_srst || buf_rst) begin
      o_empty_flag_out <= 1'b1;
      o_full_flag_out  <= 1'b0;
    end else if (bypass) begin
      o_empty_flag_out <= 1'b0;
      o_full_flag_out  <= 1'b0;
    end else begin
      o_empty_flag_out <= count_d == 11'h000;
      o_full_flag_out  <= count_d == depth;
    end
  end

  // ============================================================
  // Output port and strobe
  // Bypass strobe runs at half the core rate: one edge per core cycle only
  logic phase_q;
  logic rest;

  assign rest = !ctrl_q.strobe_edge_select;

  always_ff @(posedge i_core_clk) begin
    if (i_srst || buf_rst) begin
      o_sample_data   <= {8{rest}};
      o_output_strobe <= rest;
      phase_q         <= 1'b0;
    end else if (sd_full) begin
      o_sample_data   <= {8{rest}};
      o_output_strobe <= rest;
    end else if (bypass) begin
      phase_q <= !phase_q;
      if (!phase_q) begin
        o_sample_data   <= i_adc_sample;
        o_output_strobe <= !rest;
      end else begin
        o_output_strobe <= rest;
      end
    end else if (rd_go) begin
      o_sample_data   <= mem[rd_ptr_q];
      o_output_strobe <= !rest;
    end else if (rclk_fall || (o_empty_flag_out && !ren_s)) begin
      // Idle and empty: park at rest even after a mode or edge change
      o_output_strobe <= rest;
      if (o_empty_flag_out) begin
        o_sample_data <= {8{rest}};
      end
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  flag_reset_a: assert property ($rose(buf_rst) && !bypass |=> o_empty_flag_out
    && !o_full_flag_out) else $error("flags not reset");
  bypass_flags_a: assert property (bypass && !buf_rst |=> !o_empty_flag_out
    && !o_full_flag_out) else $error("flags active in bypass");
  full_rise_a: assert property (!buf_rst && !bypass && count_d == depth
    |=> o_full_flag_out) else $error("full flag missing");
  auto_stop_a: assert property (ctrl_q.auto_stop_on_full && !wen_rise && count_q == depth
    |-> !wr_go) else $error("write past full with auto-stop");
  wen_priority_a: assert property (wen_s |-> !rd_go)
    else $error("read during write");
  conv_sd_a: assert property (sd_conv |-> !wr_go)
    else $error("write while converter shut down");
  read_gate_a: assert property (rd_go |-> filled_q && count_q != 11'h000)
    else $error("read before fill");
  pll_bypass_a: assert property (ctrl_q.pll_ratio_select == ACBC_PLL_BYPASS
    && !$changed(ctrl_q) |=> !o_pll.enable && o_pll.mult == ACBC_MULT_1)
    else $error("pll bypass decode");
  empty_rest_a: assert property (o_empty_flag_out && !bypass && rclk_fall
    && !buf_rst && !sd_full && !$changed(ctrl_q) |=> o_output_strobe == rest
    && o_sample_data == {8{rest}}) else $error("outputs not resting");
  wen_restart_a: assert property (wen_rise && !buf_rst |=> count_q == 11'h001
    && wr_ptr_q == 10'h001 && rd_ptr_q == 10'h000 && !filled_q)
    else $error("pointers not restarted");

endmodule

// [dv/acbc_reader.sv]
// Behavioural reader that drains the capture buffer over the read port
`timescale 1ns/1ps
module acbc_reader (
  input  wire logic       i_run,
  input  wire logic       i_edge,
  input  wire logic       i_strobe,
  input  wire logic [7:0] i_data,
  output logic            o_rclk,
  output logic            o_ren
);
  logic [7:0] q[$];

  // ============================================================
  // Read clock and enable
  initial begin
    o_rclk = 1'b0;
    o_ren  = 1'b0;
    forever begin
      wait (i_run);
      #7;
      o_ren = 1'b1;
      // Clock is parked low between frames to keep it quiet
      while (i_run) begin
        #80 o_rclk = i_run;
        #80 o_rclk = 1'b0;
      end
      o_ren = 1'b0;
    end
  end

  // ============================================================
  // Capture on the strobe rather than on our own clock
  always @(i_strobe) begin
    if (i_strobe === i_edge) begin
      #1 q.push_back(i_data);
    end
  end
endmodule

// [dv/acbc_top_tb.sv]
// Self-checking bench for the capture buffer control block
`timescale 1ns/1ps
module acbc_top_tb;
  import acbc_pkg::*;
  logic        clk    = 1'b0;
  logic        srst   = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [7:0]  cnt    = 8'h00;
  logic        hold   = 1'b1;
  logic        brst   = 1'b0;
  logic        wen    = 1'b0;
  logic        run    = 1'b0;
  logic        esel   = 1'b1;
  logic        rclk, ren, hready, hresp, strobe, empty, full, pdn;
  logic [31:0] hrdata, rd;
  logic [7:0]  dout, base, e;
  acbc_pll_t   pll;
  int          fails      = 0;
  int          num_checks = 0;

  always #10 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 8'h01;

  acbc_top dut (
    .i_core_clk             (clk),
    .i_srst                 (srst),
    .i_hsel                 (hsel),
    .i_haddr                (haddr),
    .i_htrans               (htrans),
    .i_hwrite               (hwrite),
    .i_hsize                (3'h2),
    .i_hwdata               (hwdata),
    .i_hready               (hready),
    .o_hrdata               (hrdata),
    .o_hreadyout            (hready),
    .o_hresp                (hresp),
    .i_adc_sample           (hold ? 8'hA5 : cnt),
    .i_buffer_reset         (brst),
    .i_capture_write_enable (wen),
    .i_buffer_read_enable   (ren),
    .i_buffer_read_clock    (rclk),
    .o_sample_data          (dout),
    .o_output_strobe        (strobe),
    .o_empty_flag_out       (empty),
    .o_full_flag_out        (full),
    .o_converter_power_down (pdn),
    .o_pll                  (pll)
  );

  acbc_reader rdr (
    .i_run    (run),
    .i_edge   (esel),
    .i_strobe (strobe),
    .i_data   (dout),
    .o_rclk   (rclk),
    .o_ren    (ren)
  );

  // ============================================================
  // Shared tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic ctrl(input logic [7:0] v);
    ahb(1'b1, ACBC_CTRL_ADDR, {24'h0, v});
    esel <= v[ACBC_F_EDGE];
    cyc(3);
  endtask

  // Waits for n more captured bytes; the watchdog bounds the wait
  task automatic read_n(input int n);
    int t;
    t = rdr.q.size() + n;
    run <= 1'b1;
    while (rdr.q.size() < t) @(posedge clk);
    run <= 1'b0;
    cyc(16);
  endtask

  task automatic read_idle();
    run <= 1'b1;
    cyc(40);
    run <= 1'b0;
    cyc(16);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_regs();
    ahb(1'b0, ACBC_CTRL_ADDR, '0);
    chk("ctrl reset", 32'h0000_0020, rd);
    chk("hresp", 32'h0000_0000, hresp);
    chk("hready", 32'h0000_0001, hready);
    ahb(1'b0, 32'h0000_0040, '0);
    chk("unmapped", 32'h0000_0000, rd);
    wen <= 1'b1;
    cyc(8);
    chk("bypass flags", 32'h0000_0000, {empty, full});
    e = {7'h0, strobe};
    cyc(1);
    chk("bypass strobe", {31'h0, ~e[0]}, strobe);
    wen <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      ctrl(8'h20 | 8'(r << 2));
      chk("pll", {(r != 0), 4'h1 << r}, pll);
    end
  endtask

  task automatic t_fill();
    ctrl(8'h31);
    rdr.q.delete();
    chk("empty idle", 32'h1, empty);
    wen <= 1'b1;
    cyc(20);
    wen <= 1'b0;
    cyc(5);
    chk("empty written", 32'h0, empty);
    read_idle();
    chk("early read", 32'h0, rdr.q.size());
    hold <= 1'b0;
    wen  <= 1'b1;
    base = cnt;
    while (full !== 1'b1) @(posedge clk);
    cyc(20);
    ahb(1'b0, ACBC_STATUS_ADDR, '0);
    chk("count full", 32'h100, rd[26:16]);
    wen <= 1'b0;
    cyc(5);
    read_n(100);
    e = rdr.q[0] - base;
    chk("restart", 32'h1, e < 8'h08);
    chk("full cleared", 32'h0, full);
    ahb(1'b0, ACBC_STATUS_ADDR, '0);
    chk("partial", 32'h9C, rd[26:16]);
    read_n(156);
    for (int i = 0; i < 256; i++) begin
      e = rdr.q[0] + 8'(i);
      chk("order", e, rdr.q[i]);
    end
    chk("empty drained", 32'h1, empty);
    chk("rest low", 32'h0, {strobe, dout});
    read_idle();
    chk("no reread", 32'h100, rdr.q.size());
  endtask

  task automatic t_wrap();
    ctrl(8'h01);
    rdr.q.delete();
    wen  <= 1'b1;
    base = cnt;
    while (full !== 1'b1) @(posedge clk);
    cyc(30);
    chk("wrap full", 32'h1, full);
    wen <= 1'b0;
    cyc(5);
    read_n(10);
    e = rdr.q[0] - base;
    chk("oldest gone", 32'h1, e > 8'h10);
    brst <= 1'b1;
    cyc(4);
    brst <= 1'b0;
    cyc(6);
    chk("reset flags", 32'h2, {empty, full});
    chk("rest high", 32'h1FF, {strobe, dout});
  endtask

  task automatic t_shut();
    ctrl(8'h81);
    chk("adc off", 32'h1, pdn);
    wen <= 1'b1;
    cyc(20);
    wen <= 1'b0;
    cyc(5);
    ahb(1'b0, ACBC_STATUS_ADDR, '0);
    chk("no capture", 32'h0, rd[26:16]);
    ctrl(8'h41);
    chk("all off", 32'h1, pdn);
  endtask

  task automatic t_prio();
    ctrl(8'h31);
    rdr.q.delete();
    wen <= 1'b1;
    while (full !== 1'b1) @(posedge clk);
    read_idle();
    chk("write wins", 32'h0, rdr.q.size());
    wen <= 1'b0;
    cyc(5);
    ctrl(8'hB1);
    read_n(4);
    chk("read adc off", 32'h4, rdr.q.size());
    e = rdr.q[0] + 8'h01;
    chk("adc off order", e, rdr.q[1]);
    ctrl(8'h71);
    read_idle();
    chk("off no read", 32'h4, rdr.q.size());
    chk("off rest", 32'h0, {strobe, dout});
  endtask

  // ============================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_fill();
    t_wrap();
    t_shut();
    t_prio();
    end_of_test();
  end

  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule
